// ==== logic/rirq_top.sv ====
`timescale 1ns/1ps
`include "rirq_regs.svh"

module rirq_top #(
   parameter int FIFO_DEPTH = `RIRQ_FIFO_DEPTH
) (
   input  wire logic                i_ref_clk,
   input  wire logic                i_rstn,
   input  wire logic                i_clk_en,
   input  wire rirq_pkg::rirq_addr_t i_bus_addr,
   input  wire logic                i_bus_wr,
   input  wire logic                i_bus_rd,
   input  wire rirq_pkg::rirq_byte_t i_bus_wdata,
   output      rirq_pkg::rirq_byte_t o_bus_rdata,
   input  wire logic                i_fifo_flush,
   input  wire logic [5:0]          i_fifo_threshold,
   input  wire logic                i_timer_active_flag,
   input  wire logic                i_timer_hit_zero,
   input  wire logic                i_nvm_write_done,
   input  wire logic                i_checksum_done,
   input  wire logic [2:0]          i_last_byte_valid_bits,
   input  wire logic                i_transceive_sent,
   input  wire logic                i_auth_sent,
   input  wire logic                i_nvm_programmed,
   input  wire logic                i_checksum_processed,
   input  wire logic                i_rx_terminated,
   input  wire rirq_pkg::rirq_cmd_t i_cmd_code,
   input  wire logic                i_cmd_host_write,
   input  wire logic                i_cmd_unknown_start,
   output      logic [6:0]          o_fifo_fill_count,
   output      logic                o_fifo_nearly_full,
   output      logic                o_fifo_nearly_empty,
   output      logic                o_irq_pending,
   output      logic                o_irq
);
   localparam int CW = 7;

   if (FIFO_DEPTH < 2 || FIFO_DEPTH > 64) begin : g_bad_depth
      $error("rirq_top: FIFO depth must fit the seven-bit count.");
   end

   localparam logic [CW-1:0] DEPTH_C = CW'(FIFO_DEPTH);

   function automatic logic at_most(input logic [CW-1:0] a, input logic [5:0] lim);
      at_most = (a <= {1'b0, lim});
   endfunction : at_most

   function automatic logic hit(input rirq_pkg::rirq_addr_t a, input rirq_pkg::rirq_addr_t ofs);
      hit = (a == ofs);
   endfunction : hit

   // Bus decode.
   logic fifo_wr;
   logic fifo_rd;
   logic mask_wr;
   logic flag_wr;
   assign fifo_wr = i_bus_wr && hit(i_bus_addr, `RIRQ_OFS_FIFO_DATA);
   assign fifo_rd = i_bus_rd && hit(i_bus_addr, `RIRQ_OFS_FIFO_DATA);
   assign mask_wr = i_bus_wr && hit(i_bus_addr, `RIRQ_OFS_IRQ_MASK);
   assign flag_wr = i_bus_wr && hit(i_bus_addr, `RIRQ_OFS_IRQ_FLAGS);

   // FIFO byte count. Writes to a full FIFO and reads from an empty one are
   // dropped, so the count never wraps even when the host misbehaves.
   logic [CW-1:0] fill_count;
   logic [CW-1:0] next_fill_count;
   logic          do_inc;
   logic          do_dec;
   assign do_inc = fifo_wr && (fill_count < DEPTH_C);
   assign do_dec = fifo_rd && (fill_count != '0);

   always_comb begin
      next_fill_count = fill_count;
      if (i_fifo_flush) begin
         next_fill_count = '0;
      end else if (do_inc && !do_dec) begin
         next_fill_count = fill_count + 7'h01;
      end else if (do_dec && !do_inc) begin
         next_fill_count = fill_count - 7'h01;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         fill_count <= CW'(`RIRQ_RST_FIFO_COUNT);
      end else if (i_clk_en) begin
         fill_count <= next_fill_count;
      end
   end
   assign o_fifo_fill_count = fill_count;

   // Alert conditions and their rising edges.
   logic nearly_full;
   logic nearly_empty;
   logic nearly_full_q;
   logic nearly_empty_q;
   assign nearly_full  = at_most(DEPTH_C - fill_count, i_fifo_threshold);
   assign nearly_empty = at_most(fill_count, i_fifo_threshold);

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         // The FIFO is empty after reset and so already nearly empty; the low
         // detector starts high, or a false edge would set the low request flag.
         nearly_full_q  <= 1'b0;
         nearly_empty_q <= 1'b1;
      end else if (i_clk_en) begin
         nearly_full_q  <= nearly_full;
         nearly_empty_q <= nearly_empty;
      end
   end
   assign o_fifo_nearly_full  = nearly_full;
   assign o_fifo_nearly_empty = nearly_empty;

   // Command tracking for the idle request.
   rirq_pkg::rirq_cmd_t prev_cmd;
   logic                idle_event;
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         prev_cmd <= `RIRQ_CMD_IDLE;
      end else if (i_clk_en) begin
         prev_cmd <= i_cmd_code;
      end
   end

   // A return to idle written by the host is a start, not a termination.
   assign idle_event = ((i_cmd_code == `RIRQ_CMD_IDLE) && (prev_cmd != `RIRQ_CMD_IDLE)
                        && !i_cmd_host_write)
                       || i_cmd_unknown_start;

   // Hardware set requests.
   rirq_pkg::rirq_src_t hw_set;
   always_comb begin
      hw_set = '0;
      hw_set[`RIRQ_SRC_TIMER] = i_timer_hit_zero;
      hw_set[`RIRQ_SRC_TX]    = i_transceive_sent || i_auth_sent
                                || i_nvm_programmed || i_checksum_processed;
      hw_set[`RIRQ_SRC_RX]    = i_rx_terminated;
      hw_set[`RIRQ_SRC_IDLE]  = idle_event;
      hw_set[`RIRQ_SRC_HIGH]  = nearly_full && !nearly_full_q;
      hw_set[`RIRQ_SRC_LOW]   = nearly_empty && !nearly_empty_q;
   end

   // Mask and flag registers share the set/clear structure.
   rirq_sc_if #(.W(6)) mask_if ();
   rirq_sc_if #(.W(6)) flag_if ();

   assign mask_if.wr      = mask_wr;
   assign mask_if.set_sel = i_bus_wdata[`RIRQ_SEL_BIT];
   assign mask_if.bits    = i_bus_wdata[5:0];
   assign mask_if.hw_set  = '0;

   assign flag_if.wr      = flag_wr;
   assign flag_if.set_sel = i_bus_wdata[`RIRQ_SEL_BIT];
   assign flag_if.bits    = i_bus_wdata[5:0];
   assign flag_if.hw_set  = hw_set;

   rirq_setclr_reg #(
      .W         (6),
      .RST_VALUE (6'(`RIRQ_RST_IRQ_MASK))
   ) u_mask (
      .i_ref_clk (i_ref_clk),
      .i_rstn    (i_rstn),
      .i_clk_en  (i_clk_en),
      .sc        (mask_if.reg_side)
   );

   rirq_setclr_reg #(
      .W         (6),
      .RST_VALUE (6'(`RIRQ_RST_IRQ_FLAGS))
   ) u_flags (
      .i_ref_clk (i_ref_clk),
      .i_rstn    (i_rstn),
      .i_clk_en  (i_clk_en),
      .sc        (flag_if.reg_side)
   );

   rirq_pkg::rirq_src_t mask;
   rirq_pkg::rirq_src_t flags;
   assign mask  = mask_if.value;
   assign flags = flag_if.value;

   // The pin follows the stored bits directly, so it tracks a clear at once.
   assign o_irq_pending = |(flags & mask);
   assign o_irq         = |(flags & mask);

   // Read data is registered; unmapped offsets read as zero.
   rirq_pkg::rirq_byte_t next_rdata;
   always_comb begin
      next_rdata = 8'h00;
      if (hit(i_bus_addr, `RIRQ_OFS_PRIMARY)) begin
         next_rdata[`RIRQ_PRI_IRQ]  = o_irq_pending;
         next_rdata[`RIRQ_PRI_HIGH] = nearly_full;
         next_rdata[`RIRQ_PRI_LOW]  = nearly_empty;
      end else if (hit(i_bus_addr, `RIRQ_OFS_FIFO_COUNT)) begin
         next_rdata = {1'b0, fill_count};
      end else if (hit(i_bus_addr, `RIRQ_OFS_AUX_STATUS)) begin
         next_rdata[`RIRQ_AUX_TIMER]    = i_timer_active_flag;
         next_rdata[`RIRQ_AUX_NVM]      = i_nvm_write_done;
         next_rdata[`RIRQ_AUX_CHECKSUM] = i_checksum_done;
         next_rdata[2:0]                = i_last_byte_valid_bits;
      end else if (hit(i_bus_addr, `RIRQ_OFS_IRQ_MASK)) begin
         next_rdata = {2'b00, mask};
      end else if (hit(i_bus_addr, `RIRQ_OFS_IRQ_FLAGS)) begin
         next_rdata = {2'b00, flags};
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_bus_rdata <= 8'h00;
      end else if (i_clk_en && i_bus_rd) begin
         o_bus_rdata <= next_rdata;
      end
   end

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rstn);

   a_count_push:
   assert property (i_clk_en && do_inc && !fifo_rd && !i_fifo_flush
                    |=> fill_count == $past(fill_count) + 7'h01)
      else $error("FIFO count did not rise on a host write.");

   a_count_pop:
   assert property (i_clk_en && do_dec && !fifo_wr && !i_fifo_flush
                    |=> fill_count == $past(fill_count) - 7'h01)
      else $error("FIFO count did not fall on a host read.");

   a_count_bound:
   assert property (fill_count <= DEPTH_C)
      else $error("FIFO count passed the depth.");

   a_timer_flag_set:
   assert property (i_clk_en && i_timer_hit_zero |=> flags[`RIRQ_SRC_TIMER])
      else $error("Timer request flag missed a count to zero.");

   a_tx_flag_set:
   assert property (i_clk_en && (i_transceive_sent || i_auth_sent || i_nvm_programmed
                    || i_checksum_processed) |=> flags[`RIRQ_SRC_TX])
      else $error("Transmit request flag missed a finished command.");

   a_idle_host_start:
   assert property (i_clk_en && i_cmd_host_write && !i_cmd_unknown_start
                    && !flags[`RIRQ_SRC_IDLE] && !(flag_wr && i_bus_wdata[7])
                    |=> !flags[`RIRQ_SRC_IDLE])
      else $error("Host start of idle set the idle flag.");

   a_idle_return:
   assert property (i_clk_en && i_cmd_code == `RIRQ_CMD_IDLE && prev_cmd != `RIRQ_CMD_IDLE
                    && !i_cmd_host_write |=> flags[`RIRQ_SRC_IDLE])
      else $error("Idle flag missed a command termination.");

   a_mask_set_clear:
   assert property (i_clk_en && mask_wr |=> mask == ($past(i_bus_wdata[7])
                    ? ($past(mask) | $past(i_bus_wdata[5:0]))
                    : ($past(mask) & ~$past(i_bus_wdata[5:0]))))
      else $error("Mask did not follow a selector write.");

   a_alert_latch:
   assert property (flags[`RIRQ_SRC_HIGH] && !flag_wr ##1 !nearly_full
                    |-> flags[`RIRQ_SRC_HIGH])
      else $error("High alert flag dropped without a host clear.");

   a_high_alert_set:
   assert property (i_clk_en && nearly_full && !nearly_full_q |=> flags[`RIRQ_SRC_HIGH])
      else $error("High alert flag missed a rising condition.");

   a_low_alert_set:
   assert property (i_clk_en && nearly_empty && !nearly_empty_q |=> flags[`RIRQ_SRC_LOW])
      else $error("Low alert flag missed a rising condition.");

   a_flag_set_clear:
   assert property (i_clk_en && flag_wr && hw_set == 6'h00
                    |=> flags == ($past(i_bus_wdata[7])
                    ? ($past(flags) | $past(i_bus_wdata[5:0]))
                    : ($past(flags) & ~$past(i_bus_wdata[5:0]))))
      else $error("Request flags did not follow a selector write.");

   a_aux_status_read:
   assert property (i_clk_en && i_bus_rd && i_bus_addr == `RIRQ_OFS_AUX_STATUS
                    |=> o_bus_rdata == $past({i_timer_active_flag, i_nvm_write_done,
                                              i_checksum_done, 2'b00, i_last_byte_valid_bits}))
      else $error("Auxiliary status read did not show the live status inputs.");

   a_irq_pin:
   assert property (i_clk_en && flag_wr && i_bus_wdata[7] && |(i_bus_wdata[5:0] & mask)
                    |=> o_irq)
      else $error("Interrupt pin stayed low with an enabled flag set.");

   c_fifo_fill:  cover property (fill_count == DEPTH_C);
   c_irq_raise:  cover property (!o_irq ##1 o_irq);
   c_idle_event: cover property (idle_event && i_clk_en);
   c_flag_clear: cover property (flag_wr && !i_bus_wdata[7] && o_irq ##1 !o_irq);
endmodule : rirq_top

// ==== logic/rirq_regs.svh ====
`ifndef RIRQ_REGS_SVH
`define RIRQ_REGS_SVH

// Register byte offsets on the parallel bus.
`define RIRQ_OFS_FIFO_DATA   6'h02
`define RIRQ_OFS_PRIMARY     6'h03
`define RIRQ_OFS_FIFO_COUNT  6'h04
`define RIRQ_OFS_AUX_STATUS  6'h05
`define RIRQ_OFS_IRQ_MASK    6'h06
`define RIRQ_OFS_IRQ_FLAGS   6'h07

// Reset values.
`define RIRQ_RST_FIFO_COUNT  8'h00
`define RIRQ_RST_AUX_STATUS  8'h60
`define RIRQ_RST_IRQ_MASK    8'h00
`define RIRQ_RST_IRQ_FLAGS   8'h00

// Selector bit of the mask and flag registers.
`define RIRQ_SEL_BIT         7

// Interrupt source positions in mask and flags.
`define RIRQ_SRC_TIMER       5
`define RIRQ_SRC_TX          4
`define RIRQ_SRC_RX          3
`define RIRQ_SRC_IDLE        2
`define RIRQ_SRC_HIGH        1
`define RIRQ_SRC_LOW         0

// Auxiliary status field positions.
`define RIRQ_AUX_TIMER       7
`define RIRQ_AUX_NVM         6
`define RIRQ_AUX_CHECKSUM    5

// Primary status bit positions served here.
`define RIRQ_PRI_IRQ         3
`define RIRQ_PRI_HIGH        1
`define RIRQ_PRI_LOW         0

// Documented FIFO depth and the code of the idle command.
`define RIRQ_FIFO_DEPTH      64
`define RIRQ_CMD_IDLE        6'h00

`endif

// ==== logic/rirq_pkg.sv ====
package rirq_pkg;
   typedef logic [7:0] rirq_byte_t;
   typedef logic [5:0] rirq_src_t;
   typedef logic [5:0] rirq_addr_t;
   typedef logic [5:0] rirq_cmd_t;
endpackage : rirq_pkg

// ==== logic/rirq_sc_if.sv ====
`timescale 1ns/1ps
// Carries one set/clear register's host write and hardware set requests.
interface rirq_sc_if #(
   parameter int W = 6
);
   logic         wr;
   logic         set_sel;
   logic [W-1:0] bits;
   logic [W-1:0] hw_set;
   logic [W-1:0] value;

   modport reg_side (
      input  wr,
      input  set_sel,
      input  bits,
      input  hw_set,
      output value
   );
   modport ctl_side (
      output wr,
      output set_sel,
      output bits,
      output hw_set,
      input  value
   );
endinterface : rirq_sc_if

// ==== logic/rirq_setclr_reg.sv ====
`timescale 1ns/1ps
// Register whose bits the host only sets or clears by marking them.
module rirq_setclr_reg #(
   parameter int             W         = 6,
   parameter logic [W-1:0]   RST_VALUE = '0
) (
   input  wire logic   i_ref_clk,
   input  wire logic   i_rstn,
   input  wire logic   i_clk_en,
   rirq_sc_if.reg_side sc
);
   logic [W-1:0] value;
   logic [W-1:0] next_value;

   if (W < 1 || W > 7) begin : g_bad_width
      $error("rirq_setclr_reg: width must leave room for the selector bit.");
   end

   // A hardware set in the same cycle as a host clear wins, so no event is lost.
   always_comb begin
      next_value = value;
      if (sc.wr) begin
         if (sc.set_sel) begin
            next_value = value | sc.bits;
         end else begin
            next_value = value & ~sc.bits;
         end
      end
      next_value = next_value | sc.hw_set;
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         value <= RST_VALUE;
      end else if (i_clk_en) begin
         value <= next_value;
      end
   end

   assign sc.value = value;
endmodule : rirq_setclr_reg

// ==== verif/rirq_host_model.sv ====
`timescale 1ns/1ps
// Host microprocessor on the parallel bus; one strobe cycle for every access.
module rirq_host_model (
   input  wire logic                 i_ref_clk,
   output      rirq_pkg::rirq_addr_t o_addr,
   output      logic                 o_wr,
   output      logic                 o_rd,
   output      rirq_pkg::rirq_byte_t o_wdata,
   input  wire rirq_pkg::rirq_byte_t i_rdata
);
   initial begin
      o_addr  = 6'h3f;
      o_wr    = 1'b0;
      o_rd    = 1'b0;
      o_wdata = 8'h00;
   end

   // Mask and flag bytes always carry their selector in bit 7.
   task automatic wr(input rirq_pkg::rirq_addr_t a, input rirq_pkg::rirq_byte_t d);
      @(posedge i_ref_clk);
      o_addr  <= a;
      o_wdata <= d;
      o_wr    <= 1'b1;
      @(posedge i_ref_clk);
      // Released lines show the inverse so a stale value cannot pass for a held one.
      o_wr    <= 1'b0;
      o_addr  <= ~a;
      o_wdata <= ~d;
      #1;
   endtask : wr

   task automatic rd(input rirq_pkg::rirq_addr_t a, output rirq_pkg::rirq_byte_t d);
      @(posedge i_ref_clk);
      o_addr <= a;
      o_rd   <= 1'b1;
      @(posedge i_ref_clk);
      o_rd   <= 1'b0;
      o_addr <= ~a;
      #1;
      d = i_rdata;
   endtask : rd
endmodule : rirq_host_model

// ==== verif/tb_rirq_top.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin error_cnt++; \
   $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_rirq_top;
   logic                 clk   = 1'b0;
   logic                 rstn  = 1'b0;
   logic                 ce    = 1'b1;
   logic [8:0]           ev    = '0;
   logic                 tact  = 1'b0;
   logic                 nvmd  = 1'b1;
   logic                 ckd   = 1'b1;
   logic [2:0]           lbits = 3'h0;
   logic [5:0]           thr   = 6'h04;
   rirq_pkg::rirq_cmd_t  cmd   = 6'h00;
   rirq_pkg::rirq_addr_t addr;
   logic                 wr;
   logic                 rd;
   rirq_pkg::rirq_byte_t wdata;
   rirq_pkg::rirq_byte_t rdata;
   rirq_pkg::rirq_byte_t rdv;
   logic [6:0]           fill;
   logic                 nfull;
   logic                 nempty;
   logic                 pend;
   logic                 irq;
   int                   error_cnt  = 0;
   int                   n_compared = 0;
   int                   eb[7] = '{5, 4, 4, 4, 4, 3, 2};
   logic [5:0]           apat[4] = '{6'h27, 6'h10, 6'h0d, 6'h3a};
   logic [7:0]           wv[4] = '{8'hbf, 8'h05, 8'h80, 8'hc0};
   logic [7:0]           xv[4] = '{8'h3f, 8'h3a, 8'h3a, 8'h3a};

   always #12.5 clk = ~clk;

   rirq_host_model rirq_host_model_inst (.i_ref_clk(clk), .o_addr(addr), .o_wr(wr),
      .o_rd(rd), .o_wdata(wdata), .i_rdata(rdata));

   rirq_top rirq_top_inst (.i_ref_clk(clk), .i_rstn(rstn), .i_clk_en(ce),
      .i_bus_addr(addr), .i_bus_wr(wr), .i_bus_rd(rd), .i_bus_wdata(wdata),
      .o_bus_rdata(rdata), .i_fifo_flush(ev[8]), .i_fifo_threshold(thr),
      .i_timer_active_flag(tact), .i_timer_hit_zero(ev[0]), .i_nvm_write_done(nvmd),
      .i_checksum_done(ckd), .i_last_byte_valid_bits(lbits), .i_transceive_sent(ev[1]),
      .i_auth_sent(ev[2]), .i_nvm_programmed(ev[3]), .i_checksum_processed(ev[4]),
      .i_rx_terminated(ev[5]), .i_cmd_code(cmd), .i_cmd_host_write(ev[7]),
      .i_cmd_unknown_start(ev[6]), .o_fifo_fill_count(fill), .o_fifo_nearly_full(nfull),
      .o_fifo_nearly_empty(nempty), .o_irq_pending(pend), .o_irq(irq));

   task automatic pulse(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev    <= '0;
      #1;
   endtask : pulse

   task automatic chk(input string nm, input rirq_pkg::rirq_addr_t a, input logic [7:0] ex);
      rirq_host_model_inst.rd(a, rdv);
      `CHK(nm, ex, rdv)
   endtask : chk

   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report

   initial begin
      // The whole sequence needs well under a thousand cycles.
      #(20000 * 25);
      error_cnt++;
      final_report();
   end

   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      chk("count", 6'h04, 8'h00);
      chk("aux", 6'h05, 8'h60);
      chk("mask", 6'h06, 8'h00);
      chk("flags", 6'h07, 8'h00);
      rirq_host_model_inst.wr(6'h3f, 8'hbf);
      chk("unmapped", 6'h3f, 8'h00);
      chk("mask", 6'h06, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         {tact, nvmd, ckd, lbits} <= apat[i];
         chk("aux", 6'h05, {apat[i][5:3], 2'b00, apat[i][2:0]});
      end
      $display("test aux done");
      pulse(8);
      repeat (3) rirq_host_model_inst.wr(6'h02, 8'h5a);
      rirq_host_model_inst.rd(6'h02, rdv);
      chk("count", 6'h04, 8'h02);
      `CHK("near_empty", 1'b1, nempty)
      rirq_host_model_inst.wr(6'h07, 8'h3f);
      repeat (57) rirq_host_model_inst.wr(6'h02, 8'h5a);
      `CHK("near_full", 1'b0, nfull)
      rirq_host_model_inst.wr(6'h02, 8'h5a);
      `CHK("fill", 7'h3c, fill)
      `CHK("near_full", 1'b1, nfull)
      chk("flags", 6'h07, 8'h02);
      pulse(8);
      chk("flags", 6'h07, 8'h03);
      rirq_host_model_inst.wr(6'h07, 8'h02);
      chk("flags", 6'h07, 8'h01);
      rirq_host_model_inst.wr(6'h07, 8'h3f);
      $display("test fifo done");
      for (int r = 0; r < 2; r++) begin
         for (int i = 0; i < 4; i++) begin
            rirq_host_model_inst.wr(6'h06 + r[5:0], wv[i]);
            chk("setclr", 6'h06 + r[5:0], xv[i]);
         end
         rirq_host_model_inst.wr(6'h06 + r[5:0], 8'h3f);
      end
      $display("test setclr done");
      for (int i = 0; i < 7; i++) begin
         pulse(i);
         chk("event", 6'h07, 8'h01 << eb[i]);
         rirq_host_model_inst.wr(6'h07, 8'h3f);
      end
      @(posedge clk);
      cmd <= 6'h0c;
      repeat (2) @(posedge clk);
      cmd <= 6'h00;
      chk("idle", 6'h07, 8'h04);
      rirq_host_model_inst.wr(6'h07, 8'h3f);
      @(posedge clk);
      cmd <= 6'h0c;
      @(posedge clk);
      cmd   <= 6'h00;
      ev[7] <= 1'b1;
      @(posedge clk);
      ev <= '0;
      chk("idle_host", 6'h07, 8'h00);
      $display("test events done");
      rirq_host_model_inst.wr(6'h07, 8'hbf);
      `CHK("irq_off", 1'b0, irq)
      for (int b = 0; b < 6; b++) begin
         rirq_host_model_inst.wr(6'h06, 8'h80 | (8'h01 << b));
         `CHK("irq", 1'b1, irq)
         chk("primary", 6'h03, 8'h09);
         rirq_host_model_inst.wr(6'h06, 8'h01 << b);
      end
      rirq_host_model_inst.wr(6'h07, 8'h3e);
      rirq_host_model_inst.wr(6'h06, 8'h82);
      `CHK("irq_other", 1'b0, irq)
      `CHK("pending", 1'b0, pend)
      chk("primary", 6'h03, 8'h01);
      $display("test irq done");
      @(posedge clk);
      ce <= 1'b0;
      rirq_host_model_inst.wr(6'h02, 8'h5a);
      pulse(0);
      ce <= 1'b1;
      `CHK("frozen_fill", 7'h00, fill)
      chk("frozen_flags", 6'h07, 8'h01);
      $display("test freeze done");
      final_report();
   end
endmodule : tb_rirq_top
